// ### rtl/mtp_pkg.sv
// Constants, types and state layout for the motor thermal overload block
// Operation
// - Full load current leaves factory reset at zero, meaning unprogrammed.
// - Start with unprogrammed full load current faults and shows no-full-load code.
// - Remaining capacity is a percentage, 100 when cool, falling with heat.
// - Capacity is kept in non-volatile storage across power loss.
// - Capacity derives from full load current, service factor and trip classes.
// - Four up presses show heat code with percent; screens wrap both ways.
// - Mode setting disables protection or picks manual or automatic reset.
// - Manual reset default; restart blocked until reset key after cooling.
// - A held reset key never masks an overload trip.
// - Indicator steady on trip, flashing once reset becomes possible.
// - Automatic mode clears the trip itself after cool-down.
// - Modelling and tripping continue during bypass operation.
// - Average capacity used by last three good starts is kept readable.
// - Trip reset accepted only when capacity reaches the capacity-to-start value; a fault clears on the reset key at any capacity.
// - Rejected reset shows the reset-inhibited code.
// - All classes meet at 600 percent; class N trips after N seconds.
// - Start curve applies until at-speed, then the run curve.
// - Start class accepts only 5 through 30.
// - Run class accepts only 5, 10, 15, 20, 25 and 30.
// - Both class settings leave factory reset at class 10.
package mtp_pkg;
   // ****************************************************
   // Timing
   // ****************************************************
   localparam int CLK_NS = 4;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int TICKS_PER_S = 1000000000 / TICK_NS;
   localparam int BLINK_MS = 500;
   localparam int BLINK_TICKS = BLINK_MS * 1000000 / TICK_NS;
   localparam int COOL_S = 300;
   // ****************************************************
   // Register map (byte addresses)
   // ****************************************************
   localparam logic [7:0] REG_FLC = 8'h00;
   localparam logic [7:0] REG_SF = 8'h04;
   localparam logic [7:0] REG_START_CLASS = 8'h08;
   localparam logic [7:0] REG_RUN_CLASS = 8'h0C;
   localparam logic [7:0] REG_MODE = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_CAPACITY = 8'h18;
   localparam logic [7:0] REG_CAP_TO_START = 8'h1C;
   localparam logic [7:0] REG_DISPLAY = 8'h20;
   localparam int ST_RUNNING = 0;
   localparam int ST_TRIP = 1;
   localparam int ST_FAULT = 2;
   localparam int ST_RESET_OK = 3;
   localparam int ST_INHIBIT = 4;
   // ****************************************************
   // Reset values and limits
   // ****************************************************
   localparam logic [15:0] FLC_RST = 16'h0000;
   localparam logic [7:0] SF_RST = 8'h64;
   localparam logic [4:0] CLASS_RST = 5'h0A;
   localparam logic [4:0] CLASS_MIN = 5'h05;
   localparam logic [4:0] CLASS_MAX = 5'h1E;
   localparam logic [4:0] RUN_STEP = 5'h05;
   localparam logic [6:0] CTS_RST = 7'h32;
   localparam logic [23:0] SF_DIV = 24'h000064;
   // ****************************************************
   // Thermal scaling: capacity units are percent << 20
   // ****************************************************
   localparam int CAP_W = 27;
   localparam int PCT_SHIFT = 20;
   localparam logic [26:0] CAP_FULL = 27'h6400000;
   localparam int REF_RATIO = 6;
   localparam int HEAT_GAIN = 104857600 / (REF_RATIO * REF_RATIO * TICKS_PER_S);
   localparam logic [26:0] COOL_STEP = 27'(104857600 / (COOL_S * TICKS_PER_S));
   localparam logic [23:0] ONE_SQ = 24'h010000;
   localparam logic [2:0] SCREENS = 3'h7;
   // ****************************************************
   // Types
   // ****************************************************
   typedef enum logic [1:0] {MODE_MANUAL, MODE_AUTO, MODE_OFF} mtp_mode_t;
   typedef enum logic [2:0] {
      RUN_IDLE, RUN_START, RUN_FULL, RUN_TRIP, RUN_FAULT
   } mtp_run_t;
   typedef enum logic [3:0] {
      DISP_IA, DISP_IB, DISP_IC, DISP_IAVG, DISP_HEAT, DISP_CTS, DISP_MODE,
      DISP_NOFLA, DISP_INH
   } mtp_disp_t;
   typedef struct packed {
      logic [15:0] ia;
      logic [15:0] ib;
      logic [15:0] ic;
   } mtp_phase_t;
   typedef struct packed {
      logic [15:0] flc;
      logic [7:0] sf;
      logic [4:0] startClass;
      logic [4:0] runClass;
      mtp_mode_t mode;
      mtp_run_t run;
      logic [26:0] cap;
      logic [6:0] capAtStart;
      logic [2:0][6:0] hist;
      logic [1:0] histCnt;
      logic [6:0] capToStart;
      logic [2:0] screen;
      logic inhibit;
      mtp_disp_t dispCode;
      logic [15:0] dispValue;
      logic [19:0] tickCnt;
      logic [9:0] blinkCnt;
      logic blink;
      logic ledOn;
      logic tripOut;
      logic faultOut;
      logic motorRun;
      logic waitReq;
      logic [31:0] readData;
      logic nvLoaded;
      logic nvWrite;
      logic [6:0] nvData;
   } mtp_state_t;
endpackage : mtp_pkg

// ### rtl/mtp_overload.sv
// Motor thermal overload protection with Avalon-MM register access
`timescale 1ns/1ns
module mtp_overload #(
   parameter int TICK_CYCLES = mtp_pkg::TICK_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Motor sensing and control
   input wire mtp_pkg::mtp_phase_t phaseCur,
   input wire logic startCmd,
   input wire logic stopCmd,
   input wire logic atSpeed,
   input wire logic bypassActive,
   // Operator keys
   input wire logic keyUp,
   input wire logic keyDown,
   input wire logic keyReset,
   // Non-volatile capacity store
   input wire logic [6:0] nvRestore,
   output logic [6:0] nvData,
   output logic nvWrite,
   // Status outputs
   output logic motorRun,
   output logic tripOut,
   output logic faultOut,
   output logic ledOn,
   output mtp_pkg::mtp_disp_t dispCode,
   output logic [15:0] dispValue
);
   // ****************************************************
   // Helpers
   // ****************************************************
   function automatic logic [6:0] pct(input logic [26:0] c);
      pct = c[26:20];
   endfunction : pct

   function automatic logic [11:0] bcd3(input logic [6:0] v);
      logic [6:0] h;
      logic [6:0] t;
      h = v / 7'h64;
      t = (v % 7'h64) / 7'h0A;
      bcd3 = {h[3:0], t[3:0], 4'(v % 7'h0A)};
   endfunction : bcd3

   mtp_pkg::mtp_state_t s;
   mtp_pkg::mtp_state_t n;
   logic [15:0] maxCur;
   logic [23:0] prod;
   logic [23:0] level;
   logic [23:0] ratio;
   logic [11:0] ratioC;
   logic [23:0] ratioSq;
   logic [39:0] heatRaw;
   logic [26:0] heatDec;
   logic [4:0] curClass;
   logic heating;
   logic tick;
   logic tripNow;
   logic resetOk;
   logic wrEn;
   logic [6:0] used;
   logic [8:0] histSum;
   logic [17:0] avgCur;

   // ****************************************************
   // Thermal model arithmetic
   // ****************************************************
   always_comb begin
      maxCur = phaseCur.ia;
      if (phaseCur.ib > maxCur) begin
         maxCur = phaseCur.ib;
      end
      if (phaseCur.ic > maxCur) begin
         maxCur = phaseCur.ic;
      end
      prod = 24'(s.flc) * 24'(s.sf);
      level = prod / mtp_pkg::SF_DIV;
      // Zero level would divide by zero; the ratio is forced to zero instead
      ratio = (level == 24'h000000) ? 24'h000000 :
         ({maxCur, 8'h00}) / level;
      ratioC = (ratio > 24'h000FFF) ? 12'hFFF : ratio[11:0];
      ratioSq = 24'(ratioC * ratioC);
      heating = ratioSq > mtp_pkg::ONE_SQ;
      curClass = (s.run == mtp_pkg::RUN_FULL) ? s.runClass : s.startClass;
      // class N empties full capacity in N s at six times rating
      heatRaw = 40'(ratioSq) * 40'(mtp_pkg::HEAT_GAIN);
      heatDec = 27'((heatRaw >> 16) / 40'(curClass));
      tick = s.tickCnt == 20'(TICK_CYCLES - 1);
      resetOk = pct(s.cap) >= s.capToStart;
      // bypass state is not consulted: tripping goes on regardless
      tripNow = tick && heating && heatDec >= s.cap &&
         s.mode != mtp_pkg::MODE_OFF &&
         (s.run == mtp_pkg::RUN_START || s.run == mtp_pkg::RUN_FULL);
      wrEn = avs_write && !s.waitReq;
      used = (s.capAtStart > pct(s.cap)) ? s.capAtStart - pct(s.cap) : 7'h00;
      histSum = 9'(s.hist[0]) + 9'(s.hist[1]) + 9'(s.hist[2]);
      avgCur = (18'(phaseCur.ia) + 18'(phaseCur.ib) + 18'(phaseCur.ic)) /
         18'h00003;
   end

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      n = s;
      n.nvWrite = 1'b0;
      n.tickCnt = tick ? 20'h00000 : s.tickCnt + 20'h00001;
      if (!s.nvLoaded) begin
         n.nvLoaded = 1'b1;
         n.cap = (nvRestore > 7'h64) ? mtp_pkg::CAP_FULL :
            {nvRestore, 20'h00000};
      end else if (tick) begin
         if (heating) begin
            n.cap = (heatDec >= s.cap) ? '0 : s.cap - heatDec;
         end else if (s.cap + mtp_pkg::COOL_STEP > mtp_pkg::CAP_FULL) begin
            n.cap = mtp_pkg::CAP_FULL;
         end else begin
            n.cap = s.cap + mtp_pkg::COOL_STEP;
         end
      end
      if (s.nvLoaded && pct(n.cap) != s.nvData) begin
         n.nvData = pct(n.cap);
         n.nvWrite = 1'b1;
      end
      // Register writes
      if (wrEn) begin
         unique case (avs_address)
            mtp_pkg::REG_FLC: n.flc = avs_writedata[15:0];
            mtp_pkg::REG_SF: n.sf = avs_writedata[7:0];
            mtp_pkg::REG_START_CLASS: begin
               if (avs_writedata[31:5] == '0 &&
                   avs_writedata[4:0] >= mtp_pkg::CLASS_MIN &&
                   avs_writedata[4:0] <= mtp_pkg::CLASS_MAX) begin
                  n.startClass = avs_writedata[4:0];
               end
            end
            mtp_pkg::REG_RUN_CLASS: begin
               if (avs_writedata[31:5] == '0 &&
                   avs_writedata[4:0] >= mtp_pkg::CLASS_MIN &&
                   avs_writedata[4:0] <= mtp_pkg::CLASS_MAX &&
                   avs_writedata[4:0] % mtp_pkg::RUN_STEP == 5'h00) begin
                  n.runClass = avs_writedata[4:0];
               end
            end
            mtp_pkg::REG_MODE: begin
               if (avs_writedata[31:2] == '0 && avs_writedata[1:0] != 2'h3) begin
                  n.mode = mtp_pkg::mtp_mode_t'(avs_writedata[1:0]);
               end
            end
            default: ;
         endcase
      end
      // Motor sequencing
      unique case (s.run)
         mtp_pkg::RUN_IDLE: begin
            if (startCmd) begin
               if (s.flc == mtp_pkg::FLC_RST) begin
                  n.run = mtp_pkg::RUN_FAULT;
               end else begin
                  n.run = mtp_pkg::RUN_START;
                  n.capAtStart = pct(s.cap);
               end
            end
         end
         mtp_pkg::RUN_START: begin
            if (stopCmd) begin
               n.run = mtp_pkg::RUN_IDLE;
            end else if (atSpeed) begin
               // record capacity used by this start
               n.run = mtp_pkg::RUN_FULL;
               n.hist = {s.hist[1:0], used};
               if (s.histCnt != 2'h3) begin
                  n.histCnt = s.histCnt + 2'h1;
               end
            end
         end
         mtp_pkg::RUN_FULL: begin
            if (stopCmd) begin
               n.run = mtp_pkg::RUN_IDLE;
            end
         end
         mtp_pkg::RUN_TRIP: begin
            if (s.mode == mtp_pkg::MODE_OFF) begin
               n.run = mtp_pkg::RUN_IDLE;
            end else if (s.mode == mtp_pkg::MODE_AUTO) begin
               if (resetOk) begin
                  n.run = mtp_pkg::RUN_IDLE;
               end
            end else if (keyReset) begin
               if (resetOk) begin
                  n.run = mtp_pkg::RUN_IDLE;
               end else begin
                  n.inhibit = 1'b1;
               end
            end
         end
         mtp_pkg::RUN_FAULT: begin
            if (keyReset) begin
               n.run = mtp_pkg::RUN_IDLE;
            end
         end
      endcase
      if (tripNow) begin
         n.run = mtp_pkg::RUN_TRIP;
      end
      // Fresh refusal outranks a display key in the same cycle
      if (n.run != mtp_pkg::RUN_TRIP) begin
         n.inhibit = 1'b0;
      end else if ((keyUp || keyDown) && !keyReset) begin
         n.inhibit = 1'b0;
      end
      if (s.histCnt != 2'h0) begin
         n.capToStart = 7'(histSum / 9'(s.histCnt));
      end
      if (keyUp) begin
         n.screen = (s.screen == mtp_pkg::SCREENS - 3'h1) ? 3'h0 :
            s.screen + 3'h1;
      end else if (keyDown) begin
         n.screen = (s.screen == 3'h0) ? mtp_pkg::SCREENS - 3'h1 :
            s.screen - 3'h1;
      end
      if (n.run == mtp_pkg::RUN_FAULT) begin
         n.dispCode = mtp_pkg::DISP_NOFLA;
      end else if (n.inhibit) begin
         n.dispCode = mtp_pkg::DISP_INH;
      end else begin
         n.dispCode = mtp_pkg::mtp_disp_t'({1'b0, n.screen});
      end
      unique case (n.dispCode)
         mtp_pkg::DISP_IA: n.dispValue = phaseCur.ia;
         mtp_pkg::DISP_IB: n.dispValue = phaseCur.ib;
         mtp_pkg::DISP_IC: n.dispValue = phaseCur.ic;
         mtp_pkg::DISP_IAVG: n.dispValue = avgCur[15:0];
         mtp_pkg::DISP_HEAT: n.dispValue = {4'h0, bcd3(pct(n.cap))};
         mtp_pkg::DISP_CTS: n.dispValue = {4'h0, bcd3(n.capToStart)};
         mtp_pkg::DISP_MODE: n.dispValue = {14'h0000, n.mode};
         default: n.dispValue = 16'h0000;
      endcase
      // Flash timing for the indicator
      if (tick) begin
         if (s.blinkCnt == 10'(mtp_pkg::BLINK_TICKS - 1)) begin
            n.blinkCnt = 10'h000;
            n.blink = !s.blink;
         end else begin
            n.blinkCnt = s.blinkCnt + 10'h001;
         end
      end
      n.ledOn = (n.run == mtp_pkg::RUN_TRIP) &&
         (!(pct(n.cap) >= n.capToStart) || n.blink);
      n.tripOut = n.run == mtp_pkg::RUN_TRIP;
      n.faultOut = n.run == mtp_pkg::RUN_FAULT;
      n.motorRun = n.run == mtp_pkg::RUN_START || n.run == mtp_pkg::RUN_FULL;
      // Bus: one wait cycle, then answer
      n.waitReq = 1'b1;
      if ((avs_read || avs_write) && s.waitReq) begin
         n.waitReq = 1'b0;
         n.readData = 32'h00000000;
         if (avs_read) begin
            unique case (avs_address)
               mtp_pkg::REG_FLC: n.readData = {16'h0000, s.flc};
               mtp_pkg::REG_SF: n.readData = {24'h000000, s.sf};
               mtp_pkg::REG_START_CLASS:
                  n.readData = {27'h0000000, s.startClass};
               mtp_pkg::REG_RUN_CLASS: n.readData = {27'h0000000, s.runClass};
               mtp_pkg::REG_MODE: n.readData = {30'h00000000, s.mode};
               mtp_pkg::REG_STATUS: begin
                  n.readData[mtp_pkg::ST_RUNNING] = s.motorRun;
                  n.readData[mtp_pkg::ST_TRIP] = s.tripOut;
                  n.readData[mtp_pkg::ST_FAULT] = s.faultOut;
                  n.readData[mtp_pkg::ST_RESET_OK] = resetOk;
                  n.readData[mtp_pkg::ST_INHIBIT] = s.inhibit;
               end
               mtp_pkg::REG_CAPACITY: n.readData = {25'h0000000, pct(s.cap)};
               mtp_pkg::REG_CAP_TO_START:
                  n.readData = {25'h0000000, s.capToStart};
               mtp_pkg::REG_DISPLAY:
                  n.readData = {12'h000, s.dispCode, s.dispValue};
               default: n.readData = 32'h00000000;
            endcase
         end
      end
   end

   // ****************************************************
   // State register
   // ****************************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
         s.flc <= mtp_pkg::FLC_RST;
         s.sf <= mtp_pkg::SF_RST;
         s.startClass <= mtp_pkg::CLASS_RST;
         s.runClass <= mtp_pkg::CLASS_RST;
         s.mode <= mtp_pkg::MODE_MANUAL;
         s.run <= mtp_pkg::RUN_IDLE;
         s.cap <= mtp_pkg::CAP_FULL;
         s.capToStart <= mtp_pkg::CTS_RST;
         s.dispCode <= mtp_pkg::DISP_IA;
         s.waitReq <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign avs_readdata = s.readData;
   assign avs_waitrequest = s.waitReq;
   assign nvData = s.nvData;
   assign nvWrite = s.nvWrite;
   assign motorRun = s.motorRun;
   assign tripOut = s.tripOut;
   assign faultOut = s.faultOut;
   assign ledOn = s.ledOn;
   assign dispCode = s.dispCode;
   assign dispValue = s.dispValue;

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   a_unprog_norun: assert property (
      s.flc == mtp_pkg::FLC_RST |-> !s.motorRun || $past(s.flc) != 16'h0000)
      else $error("running with unprogrammed current");
   a_nofla_fault: assert property (
      startCmd && s.run == mtp_pkg::RUN_IDLE && s.flc == 16'h0000 && !tripNow
      |=> s.faultOut && s.dispCode == mtp_pkg::DISP_NOFLA)
      else $error("missing no-current fault");
   a_cap_bound: assert property (
      s.cap <= mtp_pkg::CAP_FULL) else $error("capacity above full");
   a_trip_heldkey: assert property (
      tripNow && keyReset |=> s.tripOut && !s.motorRun)
      else $error("reset key masked trip");
   a_led_steady: assert property (
      s.tripOut && !resetOk ##1 s.tripOut && !resetOk |-> s.ledOn)
      else $error("indicator not steady");
   a_auto_clear: assert property (
      s.run == mtp_pkg::RUN_TRIP && s.mode == mtp_pkg::MODE_AUTO && resetOk
      && !tripNow |=> !s.tripOut) else $error("auto reset missed");
   a_manual_hold: assert property (
      s.run == mtp_pkg::RUN_TRIP && s.mode == mtp_pkg::MODE_MANUAL &&
      !keyReset |=> s.tripOut) else $error("trip cleared without key");
   a_inh_show: assert property (
      s.run == mtp_pkg::RUN_TRIP && s.mode == mtp_pkg::MODE_MANUAL &&
      keyReset && !resetOk && !keyUp && !keyDown
      |=> s.dispCode == mtp_pkg::DISP_INH) else $error("no inhibit code");
   a_start_class: assert property (
      s.startClass >= 5'h05 && s.startClass <= 5'h1E)
      else $error("start class out of range");
   a_run_class: assert property (
      s.runClass % 5'h05 == 5'h00 && s.runClass != 5'h00 &&
      s.runClass <= 5'h1E) else $error("run class illegal");
   a_curve_sel: assert property (
      s.run == mtp_pkg::RUN_FULL |-> curClass == s.runClass)
      else $error("wrong curve in run");
   a_bus_answer: assert property (
      (avs_read || avs_write) && s.waitReq |=> !s.waitReq ##1 s.waitReq)
      else $error("bus answer timing");

   c_trip: cover property (s.run == mtp_pkg::RUN_FULL ##1 s.tripOut);
   c_flash: cover property (s.tripOut && resetOk && s.ledOn);
   c_good_start: cover property (s.run == mtp_pkg::RUN_START ##1
      s.run == mtp_pkg::RUN_FULL);
   c_inhibit: cover property (s.dispCode == mtp_pkg::DISP_INH);
   c_bypass_trip: cover property (bypassActive && tripNow);
endmodule : mtp_overload

// ### test/mtp_partner.sv
// Far-side model: phase current sensing and capacity store
`timescale 1ns/1ns
module mtp_partner (
   // Clock
   input wire logic mclk,
   // Bench controls
   input wire logic [15:0] amps,
   input wire logic fresh,
   // Store port
   input wire logic [6:0] nvData,
   input wire logic nvWrite,
   // To the block
   output mtp_pkg::mtp_phase_t phaseCur,
   output logic [6:0] nvRestore
);
   always_ff @(posedge mclk) begin
      if (fresh) begin
         nvRestore <= 7'h64;
      end else if (nvWrite) begin
         nvRestore <= nvData;
      end
   end
   assign phaseCur = '{ia: amps, ib: amps >> 1, ic: amps >> 2};
endmodule : mtp_partner

// ### test/tb_top.sv
// Self-checking bench for the motor thermal overload block
`timescale 1ns/1ns
module tb_top;
   // Short tick keeps trip times within the run budget
   localparam int TK = 8;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, got, v;
   logic wreq, nvWrite, motorRun, tripOut, faultOut, ledOn, l;
   logic [4:0] ctl = 5'h00;
   logic atSpeed = 1'b0;
   logic bypassActive = 1'b0;
   logic fresh = 1'b1;
   logic [15:0] amps = 16'h0000;
   logic [15:0] dispValue;
   logic [6:0] nvRestore, nvData;
   logic [4:0] es, er;
   mtp_pkg::mtp_phase_t phaseCur;
   mtp_pkg::mtp_disp_t dispCode;
   int n_errors = 0;
   int n_compared = 0;
   int n, k;
   always #2 mclk = ~mclk;
   mtp_overload #(.TICK_CYCLES(TK)) mtp_overload_i (.mclk(mclk),
      .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .phaseCur(phaseCur), .startCmd(ctl[3]), .stopCmd(ctl[4]),
      .atSpeed(atSpeed), .bypassActive(bypassActive), .keyUp(ctl[0]),
      .keyDown(ctl[1]), .keyReset(ctl[2]), .nvRestore(nvRestore),
      .nvData(nvData), .nvWrite(nvWrite), .motorRun(motorRun),
      .tripOut(tripOut), .faultOut(faultOut), .ledOn(ledOn),
      .dispCode(dispCode), .dispValue(dispValue));
   mtp_partner mtp_partner_i (.mclk(mclk), .amps(amps), .fresh(fresh),
      .nvData(nvData), .nvWrite(nvWrite), .phaseCur(phaseCur),
      .nvRestore(nvRestore));
   // *****
   // Helpers
   // *****
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Request held until the edge that sees waitrequest low
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int c;
      c = 0;
      @(posedge mclk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge mclk);
         c++;
      end while (wreq !== 1'b0 && c < 64);
      if (wreq !== 1'b0) n_errors++;
      got = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(got, e);
   endtask : rdchk
   task pulse(input int i);
      @(posedge mclk);
      ctl[i] <= 1'b1;
      @(posedge mclk);
      ctl[i] <= 1'b0;
   endtask : pulse
   task waitTrip(input logic lv, input int lim);
      n = 0;
      while (tripOut !== lv && n < lim) begin
         @(posedge mclk);
         n++;
      end
   endtask : waitTrip
   task cfg(input logic [4:0] s, input logic [4:0] r, input logic [1:0] m);
      bus(1'b1, mtp_pkg::REG_FLC, 32'h0A);
      bus(1'b1, mtp_pkg::REG_START_CLASS, {27'h0, s});
      bus(1'b1, mtp_pkg::REG_RUN_CLASS, {27'h0, r});
      bus(1'b1, mtp_pkg::REG_MODE, {30'h0, m});
   endtask : cfg
   task doReset;
      sys_rst <= 1'b1;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
   endtask : doReset
   // Ratio 15 of rated current: class N trips near N*160 ticks
   function automatic logic inWin(int c, int cls);
      return c >= cls * 136 * TK && c <= cls * 184 * TK;
   endfunction : inWin
   task final_report;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (80000) @(posedge mclk);
      n_errors++;
      final_report;
   end
   // *****
   // Stimulus
   // *****
   initial begin
      void'($urandom(32'hC5BD));
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      fresh <= 1'b0;
      rdchk(mtp_pkg::REG_FLC, 32'h0);
      rdchk(mtp_pkg::REG_START_CLASS, 32'h0A);
      rdchk(mtp_pkg::REG_RUN_CLASS, 32'h0A);
      rdchk(mtp_pkg::REG_MODE, 32'h0);
      rdchk(mtp_pkg::REG_CAPACITY, 32'h64);
      repeat (4) pulse(0);
      @(posedge mclk);
      chk(32'(dispCode), 32'(mtp_pkg::DISP_HEAT));
      chk({16'h0, dispValue}, 32'h0100);
      repeat (7) pulse(1);
      repeat (3) pulse(0);
      @(posedge mclk);
      chk(32'(dispCode), 32'(mtp_pkg::DISP_IA));
      pulse(3);
      @(posedge mclk);
      chk({faultOut, motorRun}, 32'h2);
      chk(32'(dispCode), 32'(mtp_pkg::DISP_NOFLA));
      pulse(2);
      es = 5'h0A;
      er = 5'h0A;
      // Every class code, legal or not
      for (int i = 0; i < 32; i++) begin
         bus(1'b1, mtp_pkg::REG_START_CLASS, i);
         bus(1'b1, mtp_pkg::REG_RUN_CLASS, i);
         if (i >= 5 && i <= 30) es = 5'(i);
         if (i >= 5 && i <= 30 && i % 5 == 0) er = 5'(i);
         rdchk(mtp_pkg::REG_START_CLASS, {27'h0, es});
         rdchk(mtp_pkg::REG_RUN_CLASS, {27'h0, er});
      end
      v = {16'h0, 16'($urandom())};
      bus(1'b1, mtp_pkg::REG_FLC, v);
      rdchk(mtp_pkg::REG_FLC, v);
      cfg(5'h05, 5'h1E, 2'h0);
      amps <= 16'h0096;
      pulse(3);
      ctl[2] <= 1'b1;
      waitTrip(1'b1, 20000);
      chk(inWin(n, 5), 32'h1);
      ctl[2] <= 1'b0;
      amps <= 16'h0000;
      pulse(2);
      @(posedge mclk);
      chk(32'(dispCode), 32'(mtp_pkg::DISP_INH));
      repeat (600 * TK) @(posedge mclk);
      chk({ledOn, tripOut}, 32'h3);
      doReset;
      bus(1'b0, mtp_pkg::REG_CAPACITY, 32'h0);
      chk(got < 5, 32'h1);
      fresh <= 1'b1;
      doReset;
      fresh <= 1'b0;
      cfg(5'h05, 5'h0A, 2'h0);
      atSpeed <= 1'b1;
      bypassActive <= 1'b1;
      amps <= 16'h0096;
      pulse(3);
      waitTrip(1'b1, 30000);
      chk(inWin(n, 10), 32'h1);
      rdchk(mtp_pkg::REG_CAP_TO_START, 32'h0);
      amps <= 16'h0000;
      k = 0;
      l = ledOn;
      repeat (1200 * TK) begin
         @(posedge mclk);
         if (ledOn !== l) k++;
         l = ledOn;
      end
      chk(k > 0, 32'h1);
      pulse(2);
      @(posedge mclk);
      chk(tripOut, 32'h0);
      bus(1'b1, mtp_pkg::REG_MODE, 32'h1);
      amps <= 16'h0096;
      pulse(3);
      waitTrip(1'b1, 4000);
      chk(tripOut, 32'h1);
      waitTrip(1'b0, 100);
      chk(tripOut, 32'h0);
      bus(1'b1, mtp_pkg::REG_MODE, 32'h2);
      pulse(3);
      waitTrip(1'b1, 400 * TK);
      chk(tripOut, 32'h0);
      chk(motorRun, 32'h1);
      rdchk(mtp_pkg::REG_STATUS, 32'h09);
      pulse(4);
      final_report;
   end
endmodule : tb_top
